// ==== design/cssc_pkg.sv ====
/*
  cssc_pkg: constants and carrier types for the clock select and startup control block.
  assumes: fuse fields arrive as static levels; all timing counts run on clk.
*/
package cssc_pkg;

  // clock source fuse codes, 1 = unprogrammed, 0 = programmed
  localparam logic [3:0] SRC_CAL_RC      = 4'h2;
  localparam logic [3:0] SRC_RC_128K     = 4'h3;
  localparam logic [3:0] SRC_EXT_CLOCK   = 4'h0;
  localparam logic [3:0] SRC_RESERVED    = 4'h1;
  localparam logic [3:0] SRC_LOWPWR_MIN  = 4'h8;
  localparam logic [3:0] SRC_FULLSW_MIN  = 4'h6;
  localparam logic [3:0] SRC_LOWFREQ_MIN = 4'h4;
  localparam logic [3:0] SRC_LOWFREQ_MAX = 4'h5;
  localparam logic [3:0] SRC_FULLSW_MAX  = 4'h7;

  // shipped defaults
  localparam logic [3:0] DEF_SRC_FUSES   = 4'h2;
  localparam logic [1:0] DEF_SUT_FUSES   = 2'h2;
  localparam logic       DEF_DIV8_FUSE   = 1'b0;

  // time-out lengths in watchdog cycles
  localparam int unsigned TOUT_NONE  = 0;
  localparam int unsigned TOUT_SHORT = 4096;
  localparam int unsigned TOUT_LONG  = 8192;

  // oscillator start-up lengths in oscillator cycles
  localparam int unsigned OSC_EXT    = 6;
  localparam int unsigned OSC_RC     = 6;
  localparam int unsigned OSC_CER    = 258;
  localparam int unsigned OSC_CER1K  = 1024;
  localparam int unsigned OSC_XTAL   = 16384;
  localparam int unsigned OSC_LFXTAL = 32768;

  localparam int unsigned DIV_RATIO  = 8;
  localparam int unsigned CNT_W      = 16;

  typedef enum logic [5:0] {
    SRC_T_LOWPWR  = 6'h01,
    SRC_T_FULLSW  = 6'h02,
    SRC_T_LOWFREQ = 6'h04,
    SRC_T_RC128K  = 6'h08,
    SRC_T_CALRC   = 6'h10,
    SRC_T_EXT     = 6'h20
  } cssc_src_t;

  typedef enum logic [3:0] {
    ST_RESET   = 4'h1,
    ST_TIMEOUT = 4'h2,
    ST_OSC     = 4'h4,
    ST_RUN     = 4'h8
  } cssc_state_t;

  typedef struct packed {
    logic [3:0] src;
    logic [1:0] startup_time_fuses;
    logic       div8;
  } cssc_fuses_t;

  typedef struct packed {
    logic core_en;
    logic io_en;
    logic flash_en;
    logic async_en;
    logic adc_en;
  } cssc_gates_t;

endpackage : cssc_pkg

// ==== design/cssc_counter.sv ====
/*
  cssc_counter: loadable down counter with done flag.
  assumes: load is a pulse; count advances only when tick is high.
*/
`timescale 1ns/1ns
`default_nettype none
module cssc_counter #(
  parameter int unsigned W = 16
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         arst_n,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         tick,
  // status
  output var  logic         done
);
  logic [W-1:0] cnt_reg;
  wire  logic   is_zero = (cnt_reg == '0);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= '0;
    end else if (load) begin
      cnt_reg <= load_val;
    end else if (tick && !is_zero) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  assign done = is_zero && !load;
endmodule : cssc_counter
`default_nettype wire

// ==== design/cssc_divider.sv ====
/*
  cssc_divider: divides the source tick by a fixed ratio when enabled.
  assumes: src_tick is a one-cycle pulse per source clock cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module cssc_divider #(
  parameter int unsigned RATIO = 8
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // control
  input  wire logic enable,
  input  wire logic src_tick,
  // output
  output var  logic sys_tick
);
  localparam int unsigned DW = $clog2(RATIO);
  localparam logic [DW-1:0] LAST = DW'(RATIO - 1);
  logic [DW-1:0] div_reg;
  wire  logic    wrap = (div_reg == LAST);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_reg <= '0;
    end else if (src_tick) begin
      div_reg <= wrap ? '0 : div_reg + 1'b1;
    end
  end

  assign sys_tick = enable ? (src_tick && wrap) : src_tick;
endmodule : cssc_divider
`default_nettype wire

// ==== design/cssc_top.sv ====
/*
  cssc_top: clock source decode, startup sequencing and gated clock enables.
  assumes: fuses are static; reset sources, wake and sleep inputs are synchronous to clk;
  osc_tick and wdt_tick pulse once per oscillator and watchdog cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module cssc_top #(
  parameter int unsigned TOUT_SHORT_CYC = cssc_pkg::TOUT_SHORT,
  parameter int unsigned TOUT_LONG_CYC  = cssc_pkg::TOUT_LONG,
  parameter int unsigned OSC_LF_CYC     = cssc_pkg::OSC_LFXTAL,
  parameter int unsigned OSC_XT_CYC     = cssc_pkg::OSC_XTAL
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  // fuses and reset sources
  input  wire cssc_pkg::cssc_fuses_t fuses,
  input  wire logic                  ext_reset_active,
  input  wire logic                  brown_out_detector_active,
  // oscillator and watchdog ticks
  input  wire logic                  osc_tick,
  input  wire logic                  wdt_tick,
  // sleep control
  input  wire logic                  wake,
  input  wire logic                  sleep_core,
  input  wire logic                  sleep_io,
  input  wire logic                  sleep_adc,
  input  wire logic                  sleep_async,
  input  wire logic                  flash_follow_core,
  // asynchronous wake detectors
  input  wire logic                  async_irq,
  input  wire logic                  serial_start,
  input  wire logic                  two_wire_addr_match,
  // outputs
  output var  logic                  internal_reset,
  output var  cssc_pkg::cssc_src_t   src_sel,
  output var  logic                  src_reserved,
  output var  logic                  sys_tick,
  output var  cssc_pkg::cssc_gates_t gates,
  output var  logic                  wake_event
);

  // ==========================================================
  // source decode
  // ==========================================================
  // fuses read as programmed when zero
  function automatic cssc_pkg::cssc_src_t decode_src(input logic [3:0] code);
    cssc_pkg::cssc_src_t s;
    s = cssc_pkg::SRC_T_CALRC;
    if (code >= cssc_pkg::SRC_LOWPWR_MIN) begin
      s = cssc_pkg::SRC_T_LOWPWR;
    end else if (code >= cssc_pkg::SRC_FULLSW_MIN && code <= cssc_pkg::SRC_FULLSW_MAX) begin
      s = cssc_pkg::SRC_T_FULLSW;
    end else if (code >= cssc_pkg::SRC_LOWFREQ_MIN && code <= cssc_pkg::SRC_LOWFREQ_MAX) begin
      s = cssc_pkg::SRC_T_LOWFREQ;
    end else if (code == cssc_pkg::SRC_RC_128K) begin
      s = cssc_pkg::SRC_T_RC128K;
    end else if (code == cssc_pkg::SRC_EXT_CLOCK) begin
      s = cssc_pkg::SRC_T_EXT;
    end
    return s;
  endfunction : decode_src

  wire cssc_pkg::cssc_src_t src_dec  = decode_src(fuses.src);
  wire logic                res_code = (fuses.src == cssc_pkg::SRC_RESERVED);

  // ==========================================================
  // startup lengths
  // ==========================================================
  localparam int unsigned W = cssc_pkg::CNT_W + 1;
  // timeout chosen by startup and source fuses
  wire logic [1:0] tsel = {fuses.src[0], fuses.startup_time_fuses[0]};
  wire logic       crystal = src_dec inside {cssc_pkg::SRC_T_LOWPWR, cssc_pkg::SRC_T_FULLSW};
  wire logic [W-1:0] tout_len =
      (crystal && tsel == 2'h1 && fuses.startup_time_fuses[1] == 1'b0) ? W'(cssc_pkg::TOUT_NONE) :
      (fuses.startup_time_fuses == 2'h1 || fuses.startup_time_fuses == 2'h3) ? W'(TOUT_LONG_CYC) :
      (fuses.startup_time_fuses == 2'h0 && !crystal) ? W'(cssc_pkg::TOUT_NONE) :
      W'(TOUT_SHORT_CYC);
  wire logic [W-1:0] osc_len =
      (src_dec == cssc_pkg::SRC_T_EXT)     ? W'(cssc_pkg::OSC_EXT) :
      (src_dec == cssc_pkg::SRC_T_LOWFREQ) ? W'(OSC_LF_CYC) :
      (src_dec == cssc_pkg::SRC_T_CALRC ||
       src_dec == cssc_pkg::SRC_T_RC128K)  ? W'(cssc_pkg::OSC_RC) :
      (fuses.src[0])                       ? W'(OSC_XT_CYC) :
      (fuses.startup_time_fuses[1])                       ? W'(cssc_pkg::OSC_CER1K) :
      W'(cssc_pkg::OSC_CER);

  // ==========================================================
  // startup sequencer
  // ==========================================================
  cssc_pkg::cssc_state_t state_reg;
  cssc_pkg::cssc_state_t state_next;
  logic                  asleep_reg;
  logic                  asleep_next;

  wire logic others_active = ext_reset_active || brown_out_detector_active;
  wire logic tout_done;
  wire logic osc_done;
  wire logic enter_tout = (state_reg == cssc_pkg::ST_RESET) && !others_active;
  wire logic wake_go    = (state_reg == cssc_pkg::ST_RUN) && asleep_reg && wake;
  wire logic enter_osc  = ((state_reg == cssc_pkg::ST_TIMEOUT) && tout_done) || wake_go;

  always_comb begin
    state_next  = state_reg;
    asleep_next = asleep_reg;
    case (state_reg)
      cssc_pkg::ST_RESET: begin
        if (!others_active) begin
          state_next = cssc_pkg::ST_TIMEOUT;
        end
      end
      cssc_pkg::ST_TIMEOUT: begin
        if (others_active) begin
          state_next = cssc_pkg::ST_RESET;
        end else if (tout_done) begin
          state_next = cssc_pkg::ST_OSC;
        end
      end
      cssc_pkg::ST_OSC: begin
        if (others_active) begin
          state_next = cssc_pkg::ST_RESET;
        end else if (osc_done) begin
          state_next  = cssc_pkg::ST_RUN;
          asleep_next = 1'b0;
        end
      end
      cssc_pkg::ST_RUN: begin
        if (others_active) begin
          state_next = cssc_pkg::ST_RESET;
        end else if (wake_go) begin
          state_next = cssc_pkg::ST_OSC;
        end else if (sleep_core && sleep_io) begin
          asleep_next = 1'b1;
        end
      end
      default: begin
        state_next = cssc_pkg::ST_RESET;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg  <= cssc_pkg::ST_RESET;
      asleep_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      asleep_reg <= asleep_next;
    end
  end

  // timeout is a pure watchdog count
  cssc_counter #(.W(W)) u_tout (
    .clk      (clk),
    .arst_n   (arst_n),
    .load     (enter_tout),
    .load_val (tout_len),
    .tick     (wdt_tick),
    .done     (tout_done)
  );

  cssc_counter #(.W(W)) u_osc (
    .clk      (clk),
    .arst_n   (arst_n),
    .load     (enter_osc),
    .load_val (osc_len),
    .tick     (osc_tick),
    .done     (osc_done)
  );

  // ==========================================================
  // system clock divider
  // ==========================================================
  // programmed fuse divides by eight
  cssc_divider #(.RATIO(cssc_pkg::DIV_RATIO)) u_div (
    .clk      (clk),
    .arst_n   (arst_n),
    .enable   (fuses.div8 == 1'b0),
    .src_tick (osc_tick),
    .sys_tick (sys_tick)
  );

  // ==========================================================
  // clock gating
  // ==========================================================
  wire logic running = (state_reg == cssc_pkg::ST_RUN);
  cssc_pkg::cssc_gates_t gates_next;

  always_comb begin
    // each domain but flash halted by its own sleep
    gates_next.core_en  = running && !sleep_core;
    // io clock gated on its own
    gates_next.io_en    = running && !sleep_io;
    gates_next.flash_en = flash_follow_core ? (running && !sleep_core) : running;
    // async timer keeps running in sleep
    gates_next.async_en = !sleep_async;
    // converter independent of core and io
    gates_next.adc_en   = !sleep_adc;
  end

  // shipped default source until fuses sampled
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gates          <= '0;
      internal_reset <= 1'b1;
      src_sel        <= cssc_pkg::SRC_T_CALRC;
      src_reserved   <= 1'b0;
    end else begin
      gates          <= gates_next;
      internal_reset <= !running;
      src_sel        <= src_dec;
      src_reserved   <= res_code;
    end
  end

  // async interrupts seen with io clock halted
  // start detect and address match in sleep
  assign wake_event = async_irq || serial_start || two_wire_addr_match;

endmodule : cssc_top
`default_nettype wire

// ==== verif/cssc_top_asserts.sv ====
/*
  cssc_top_asserts: port-level checks for cssc_top.
  assumes: bound to cssc_top; inputs change away from the rising edge.
*/
`timescale 1ns/1ns
`default_nettype none
module cssc_top_asserts (
  // clock and reset
  input wire logic                  clk,
  input wire logic                  arst_n,
  // inputs
  input wire cssc_pkg::cssc_fuses_t fuses,
  input wire logic                  ext_reset_active,
  input wire logic                  brown_out_detector_active,
  input wire logic                  osc_tick,
  input wire logic                  sleep_adc,
  input wire logic                  sleep_async,
  input wire logic                  flash_follow_core,
  input wire logic                  async_irq,
  input wire logic                  serial_start,
  input wire logic                  two_wire_addr_match,
  // outputs
  input wire logic                  internal_reset,
  input wire cssc_pkg::cssc_src_t   src_sel,
  input wire logic                  src_reserved,
  input wire logic                  sys_tick,
  input wire cssc_pkg::cssc_gates_t gates,
  input wire logic                  wake_event
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // ==========================================
  // checks
  sequence s_osc_seen;
    $past(osc_tick, 1) || $past(osc_tick, 2) || $past(osc_tick, 3) || $past(osc_tick, 4);
  endsequence
  a_release_osc: assert property ($fell(internal_reset) |-> s_osc_seen)
    else $error("internal reset released with no recent oscillator tick");
  a_source_reset: assert property ((ext_reset_active || brown_out_detector_active) |-> ##[1:2] internal_reset)
    else $error("reset source did not hold internal reset");
  a_gates_reset: assert property (internal_reset |-> !(gates.core_en || gates.io_en || gates.flash_en))
    else $error("gated enable high during internal reset");
  a_flash_core: assert property (!internal_reset && flash_follow_core |-> gates.flash_en == gates.core_en)
    else $error("flash enable differs from core enable");
  a_async_run: assert property (1'b1 |=> gates.async_en == !$past(sleep_async))
    else $error("async timer enable does not follow its sleep input");
  a_adc_own: assert property (1'b1 |=> gates.adc_en == !$past(sleep_adc))
    else $error("converter enable does not follow its sleep input");
  a_tick_pass: assert property (fuses.div8 |-> sys_tick == osc_tick)
    else $error("undivided system tick differs from oscillator tick");
  a_tick_gap: assert property (!osc_tick |-> !sys_tick)
    else $error("system tick without oscillator tick");
  a_wake_or: assert property (wake_event == (async_irq || serial_start || two_wire_addr_match))
    else $error("wake event is not the or of the detectors");
  a_reserved_code: assert property (fuses.src == 4'h1 |=> src_reserved)
    else $error("reserved code not flagged");
  a_lowpwr_code: assert property (fuses.src[3] |=> src_sel == cssc_pkg::SRC_T_LOWPWR)
    else $error("upper codes not decoded as low power crystal");
endmodule : cssc_top_asserts
`default_nettype wire

// ==== verif/cssc_top_tb_top.sv ====
/*
  cssc_top_tb_top: self-checking bench for cssc_top with shortened counts.
  assumes: cssc_pkg and cssc_top compiled first; ticks are driven as one-cycle pulses.
*/
`timescale 1ns/1ns
`default_nettype none
module cssc_top_tb_top;
  logic                  clk = 1'b0;
  logic                  arst_n = 1'b0;
  logic                  ext_rst, brown_out_detector, osc_tick, wdt_tick, wake, s_core, s_io, s_adc, s_async;
  logic                  follow, a_irq, s_start, tw_match, ir, src_rsv, sys_tick, wake_ev;
  cssc_pkg::cssc_fuses_t fuses;
  cssc_pkg::cssc_src_t   src_sel;
  cssc_pkg::cssc_gates_t gates;
  int                    n_fail = 0;
  int                    num_checks = 0;
  int                    n_sys;

  always #20 clk = ~clk;

  cssc_top #(.TOUT_SHORT_CYC(16), .TOUT_LONG_CYC(32), .OSC_LF_CYC(16), .OSC_XT_CYC(16)) i_dut (
    .clk(clk), .arst_n(arst_n), .fuses(fuses), .ext_reset_active(ext_rst),
    .brown_out_detector_active(brown_out_detector), .osc_tick(osc_tick), .wdt_tick(wdt_tick), .wake(wake),
    .sleep_core(s_core), .sleep_io(s_io), .sleep_adc(s_adc), .sleep_async(s_async),
    .flash_follow_core(follow), .async_irq(a_irq), .serial_start(s_start),
    .two_wire_addr_match(tw_match), .internal_reset(ir), .src_sel(src_sel),
    .src_reserved(src_rsv), .sys_tick(sys_tick), .gates(gates), .wake_event(wake_ev));

  // ==========================================
  // model and helpers
  function automatic cssc_pkg::cssc_src_t src_model(input int c);
    if (c >= 8) return cssc_pkg::SRC_T_LOWPWR;
    if (c >= 6) return cssc_pkg::SRC_T_FULLSW;
    if (c >= 4) return cssc_pkg::SRC_T_LOWFREQ;
    if (c == 3) return cssc_pkg::SRC_T_RC128K;
    if (c == 0) return cssc_pkg::SRC_T_EXT;
    return cssc_pkg::SRC_T_CALRC;
  endfunction : src_model

  function automatic int tout_model(input int startup_time_fuses);
    if (startup_time_fuses % 2 == 1) return 32;
    return (startup_time_fuses == 0) ? 0 : 16;
  endfunction : tout_model

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
      n_fail++;
    end
  endtask : chk

  task automatic pulse(input bit wdt, input int n);
    repeat (n) begin
      @(negedge clk);
      if (wdt) wdt_tick = 1'b1;
      else osc_tick = 1'b1;
      @(negedge clk);
      {wdt_tick, osc_tick} = 2'b00;
    end
  endtask : pulse

  task automatic wait_rel();
    for (int k = 0; k < 12 && ir !== 1'b0; k++) @(negedge clk);
    chk("internal_reset release", ir, 1'b0);
  endtask : wait_rel

  task automatic startup(input int n, input bit use_bod);
    @(negedge clk);
    ext_rst = !use_bod;
    brown_out_detector = use_bod;
    pulse(1'b1, 3);
    pulse(1'b0, 3);
    {ext_rst, brown_out_detector} = 2'b00;
    chk("held by source", ir, 1'b1);
    if (n > 0) begin
      pulse(1'b1, n - 1);
      pulse(1'b0, 8);
      chk("timeout holds", ir, 1'b1);
      pulse(1'b1, 1);
    end
    repeat (4) @(negedge clk);
    pulse(1'b0, 5);
    repeat (3) @(negedge clk);
    chk("osc count holds", ir, 1'b1);
    pulse(1'b0, 1);
    wait_rel();
  endtask : startup

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  // ==========================================
  // tests
  initial begin
    void'($urandom(4817));
    {ext_rst, brown_out_detector, osc_tick, wdt_tick, wake, s_core, s_io, s_adc, s_async} = '0;
    {a_irq, s_start, tw_match} = '0;
    follow = 1'b1;
    fuses = {cssc_pkg::DEF_SRC_FUSES, cssc_pkg::DEF_SUT_FUSES, cssc_pkg::DEF_DIV8_FUSE};
    repeat (6) @(negedge clk);
    chk("reset gates", gates, 5'h00);
    chk("default source", src_sel, cssc_pkg::SRC_T_CALRC);
    arst_n = 1'b1;
    for (int i = 0; i < 3; i++) begin
      fuses.startup_time_fuses = 2'(2 - i);
      // zero timeout only behind brown-out source
      startup(tout_model(2 - i), i != 0);
      @(negedge clk);
      chk("run gates", gates, 5'h1f);
    end
    $display("test startup done");
    s_io = 1'b1;
    repeat (2) @(negedge clk);
    chk("io sleep gates", gates, 5'h17);
    s_core = 1'b1;
    repeat (2) @(negedge clk);
    chk("core sleep gates", gates, 5'h03);
    wake = 1'b1;
    @(negedge clk);
    wake = 1'b0;
    {s_core, s_io} = 2'b00;
    repeat (3) @(negedge clk);
    chk("wake holds reset", ir, 1'b1);
    pulse(1'b0, 6);
    wait_rel();
    $display("test wake done");
    n_sys = 0;
    repeat (16) begin
      @(negedge clk);
      osc_tick = 1'b1;
      #1 n_sys += int'(sys_tick);
      @(negedge clk);
      osc_tick = 1'b0;
    end
    chk("divided ticks", n_sys, 2);
    fuses.div8 = 1'b1;
    repeat (48) begin
      @(negedge clk);
      {osc_tick, a_irq, s_start, tw_match, s_adc, s_async} = 6'($urandom);
      #1 chk("wake event", wake_ev, a_irq | s_start | tw_match);
      chk("undivided tick", sys_tick, osc_tick);
    end
    $display("test ticks done");
    for (int c = 0; c < 16; c++) begin
      @(negedge clk);
      fuses.src = 4'(c);
      repeat (2) @(negedge clk);
      chk("source decode", src_sel, src_model(c));
      chk("reserved flag", src_rsv, 32'(c == 1));
    end
    $display("test decode done");
    finish_test();
  end
endmodule : cssc_top_tb_top

bind cssc_top cssc_top_asserts i_chk (
  .clk, .arst_n, .fuses, .ext_reset_active, .brown_out_detector_active, .osc_tick, .sleep_adc,
  .sleep_async, .flash_follow_core, .async_irq, .serial_start, .two_wire_addr_match,
  .internal_reset, .src_sel, .src_reserved, .sys_tick, .gates, .wake_event);
`default_nettype wire
